//--- verilog/mic_irq_ctrl.sv
// Purpose: interrupt request, dispatch, stack and external pin logic
// Assumes: hclk is the high-speed clock; peripheral events are
//          one-cycle pulses on hclk
// Notes: zero-wait AHB-Lite slave, read data sampled at address phase
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module mic_irq_ctrl (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [3:0] src_event_a,
   input wire logic [2:0] src_event_b,
   input wire logic [1:0] ext_irq_pin,
   input wire logic instr_boundary,
   input wire logic [12:0] next_pc,
   input wire logic return_from_irq_instr,
   input wire logic fh_clk_on,
   output mic_pkg::mic_pc_t irq_jump,
   output mic_pkg::mic_pc_t irq_return,
   output logic irq_wake
);
   // ==========================================================
   // helper functions
   function automatic logic [4:0] db_len(input logic [1:0] sel);
      db_len = (sel == 2'h1) ? mic_pkg::DB_CYC_1 :
               (sel == 2'h2) ? mic_pkg::DB_CYC_2 : mic_pkg::DB_CYC_3;
   endfunction

   function automatic logic [12:0] vec_of(input mic_pkg::mic_src_t s);
      case (s)
         mic_pkg::MIC_SRC_PIN0: vec_of = mic_pkg::VEC_PIN0;
         mic_pkg::MIC_SRC_PIN1: vec_of = mic_pkg::VEC_PIN1;
         mic_pkg::MIC_SRC_MF_A: vec_of = mic_pkg::VEC_MF_A;
         default: vec_of = mic_pkg::VEC_MF_B;
      endcase
   endfunction

   // ==========================================================
   // state
   logic [7:0] mf_a_q;
   logic [7:0] mf_a_d;
   logic [7:0] mf_b_q;
   logic [7:0] mf_b_d;
   logic [7:0] edge_q;
   logic [7:0] edge_d;
   logic [7:0] dbnc_q;
   logic [7:0] dbnc_d;
   logic [9:0] ctrl_q;
   logic [9:0] ctrl_d;
   logic [12:0] stk_q [mic_pkg::STK_DEPTH];
   logic [3:0] sp_q;
   logic [1:0] s1_q;
   logic [1:0] s2_q;
   logic [1:0] s3_q;
   logic [1:0] filt_q;
   logic [1:0] filt_prev_q;
   logic [4:0] cnt_q [2];
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic [31:0] hrdata_q;
   logic hreadyout_q;
   mic_pkg::mic_pc_t jump_q;
   mic_pkg::mic_pc_t ret_q;
   logic wake_q;

   // ==========================================================
   // bus decode
   wire addr_ok = hsel & hready & htrans[1];
   wire rd_take = addr_ok & ~hwrite;
   wire wr_a = wr_pend_q & (wr_addr_q == mic_pkg::OFS_MF_A);
   wire wr_b = wr_pend_q & (wr_addr_q == mic_pkg::OFS_MF_B);
   wire wr_e = wr_pend_q & (wr_addr_q == mic_pkg::OFS_EDGE);
   wire wr_db = wr_pend_q & (wr_addr_q == mic_pkg::OFS_DBNC);
   wire wr_c = wr_pend_q & (wr_addr_q == mic_pkg::OFS_CTRL);

   // ==========================================================
   // external pins: sync, debounce, edge detect
   wire [1:0] agree = ~(s2_q ^ s3_q);
   wire [1:0] rise = filt_q & ~filt_prev_q;
   wire [1:0] fall = ~filt_q & filt_prev_q;
   wire [1:0] pin_hit;
   wire [1:0] pin_can_wake;
   genvar gi;
   for (gi = 0; gi < 2; gi++) begin : g_pin
      wire [1:0] es = edge_q[2*gi +: 2];
      wire [1:0] ds = dbnc_q[2*gi +: 2];
      assign pin_hit[gi] = ((es == mic_pkg::EDGE_RISE) & rise[gi]) |
         ((es == mic_pkg::EDGE_FALL) & fall[gi]) |
         ((es == mic_pkg::EDGE_BOTH) & (rise[gi] | fall[gi]));
      assign pin_can_wake[gi] = (ds == mic_pkg::DB_BYPASS) | fh_clk_on;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q <= 2'h0;
         s2_q <= 2'h0;
         s3_q <= 2'h0;
      end else begin
         s1_q <= ext_irq_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         filt_q <= 2'h0;
         filt_prev_q <= 2'h0;
         cnt_q[0] <= 5'h00;
         cnt_q[1] <= 5'h00;
      end else begin
         filt_prev_q <= filt_q;
         for (int i = 0; i < 2; i++) begin
            if (dbnc_q[2*i +: 2] == mic_pkg::DB_BYPASS) begin
               cnt_q[i] <= 5'h00;
               if (agree[i])
                  filt_q[i] <= s3_q[i];
            end else if (agree[i] && s3_q[i] != filt_q[i]) begin
               if (cnt_q[i] + 5'h01 >= db_len(dbnc_q[2*i +: 2])) begin
                  filt_q[i] <= s3_q[i];
                  cnt_q[i] <= 5'h00;
               end else begin
                  cnt_q[i] <= cnt_q[i] + 5'h01;
               end
            end else begin
               cnt_q[i] <= 5'h00;
            end
         end
      end
   end

   // ==========================================================
   // pending requests and fixed priority
   wire gie = ctrl_q[mic_pkg::CTRL_GIE];
   wire [1:0] pin_en = ctrl_q[mic_pkg::CTRL_PIN_EN +: 2];
   wire [1:0] pin_flag = ctrl_q[mic_pkg::CTRL_PIN_FLAG +: 2];
   wire [1:0] mf_flag = ctrl_q[mic_pkg::CTRL_MF_FLAG +: 2];
   wire [1:0] mf_en = ctrl_q[mic_pkg::CTRL_MF_EN +: 2];
   wire [3:0] pend = {mf_flag & mf_en, pin_flag & pin_en};
   wire stack_full = (sp_q == mic_pkg::STK_FULL);
   wire take = instr_boundary & gie & (|pend) & ~stack_full;
   mic_pkg::mic_src_t sel;
   assign sel = pend[0] ? mic_pkg::MIC_SRC_PIN0 :
                pend[1] ? mic_pkg::MIC_SRC_PIN1 :
                pend[2] ? mic_pkg::MIC_SRC_MF_A : mic_pkg::MIC_SRC_MF_B;
   wire [3:0] take_clr = take ? (4'h1 << sel) : 4'h0;
   wire pop = return_from_irq_instr & (sp_q != 4'h0);

   // ==========================================================
   // register next values, hardware set wins over any clear
   wire [1:0] mf_set = {|(src_event_b & mf_b_q[2:0]),
                        |(src_event_a & mf_a_q[3:0])};
   wire [3:0] new_set = {mf_set, pin_hit};
   wire [7:0] wdat = hwdata[7:0];

   always_comb begin
      mf_a_d = wr_a ? (wdat & mic_pkg::MF_A_MASK) : mf_a_q;
      mf_a_d[7:4] = mf_a_d[7:4] | src_event_a;
      mf_b_d = wr_b ? (wdat & mic_pkg::MF_B_MASK) : mf_b_q;
      mf_b_d[6:4] = mf_b_d[6:4] | src_event_b;
      edge_d = wr_e ? (wdat & mic_pkg::PIN_REG_MASK) : edge_q;
      dbnc_d = wr_db ? (wdat & mic_pkg::PIN_REG_MASK) : dbnc_q;
      ctrl_d = wr_c ? (hwdata[9:0] & mic_pkg::CTRL_MASK) : ctrl_q;
      ctrl_d[mic_pkg::CTRL_PIN_FLAG +: 2] =
         ctrl_d[mic_pkg::CTRL_PIN_FLAG +: 2] & ~take_clr[1:0];
      ctrl_d[mic_pkg::CTRL_MF_FLAG +: 2] =
         ctrl_d[mic_pkg::CTRL_MF_FLAG +: 2] & ~take_clr[3:2];
      ctrl_d[mic_pkg::CTRL_PIN_FLAG +: 2] =
         ctrl_d[mic_pkg::CTRL_PIN_FLAG +: 2] | pin_hit;
      ctrl_d[mic_pkg::CTRL_MF_FLAG +: 2] =
         ctrl_d[mic_pkg::CTRL_MF_FLAG +: 2] | mf_set;
      if (take)
         ctrl_d[mic_pkg::CTRL_GIE] = 1'b0;
   end

   // wake on a flag newly set, not on one already standing; a debounced pin's flag wakes only while fh_clk_on
   wire [6:0] src_new = {src_event_b & ~mf_b_q[6:4],
                         src_event_a & ~mf_a_q[7:4]};
   wire [1:0] pin_new = pin_hit & ~pin_flag & pin_can_wake;
   wire wake_d = (|src_new) | (|pin_new) |
                 (|(new_set[3:2] & ~mf_flag));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mf_a_q <= mic_pkg::REG_RESET;
         mf_b_q <= mic_pkg::REG_RESET;
         edge_q <= mic_pkg::REG_RESET;
         dbnc_q <= mic_pkg::REG_RESET;
         ctrl_q <= 10'h000;
         wake_q <= 1'b0;
      end else begin
         mf_a_q <= mf_a_d;
         mf_b_q <= mf_b_d;
         edge_q <= edge_d;
         dbnc_q <= dbnc_d;
         ctrl_q <= ctrl_d;
         wake_q <= wake_d;
      end
   end

   // ==========================================================
   // stack, jump and return
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sp_q <= 4'h0;
         jump_q <= '0;
         ret_q <= '0;
      end else begin
         jump_q.valid <= take;
         ret_q.valid <= pop;
         if (take) begin
            stk_q[sp_q[2:0]] <= next_pc;
            sp_q <= sp_q + 4'h1;
            jump_q.pc <= vec_of(sel);
         end else if (pop) begin
            ret_q.pc <= stk_q[3'(sp_q - 4'h1)];
            sp_q <= sp_q - 4'h1;
         end
      end
   end

   // ==========================================================
   // AHB-Lite slave: zero wait, always OKAY
   wire [31:0] rd_mux =
      (haddr[7:0] == mic_pkg::OFS_MF_A) ? {24'h0, mf_a_q} :
      (haddr[7:0] == mic_pkg::OFS_MF_B) ? {24'h0, mf_b_q} :
      (haddr[7:0] == mic_pkg::OFS_EDGE) ? {24'h0, edge_q} :
      (haddr[7:0] == mic_pkg::OFS_DBNC) ? {24'h0, dbnc_q} :
      (haddr[7:0] == mic_pkg::OFS_CTRL) ? {22'h0, ctrl_q} :
      (haddr[7:0] == mic_pkg::OFS_STAT) ?
         {20'h0, stack_full, sp_q, filt_q, pend, 1'b0} : 32'h0;
   wire hi_zero = (haddr[31:8] == 24'h0);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata_q <= 32'h0;
         hreadyout_q <= 1'b0;
      end else begin
         hreadyout_q <= 1'b1;
         wr_pend_q <= addr_ok & hwrite & hi_zero;
         wr_addr_q <= haddr[7:0];
         if (rd_take)
            hrdata_q <= hi_zero ? rd_mux : 32'h0;
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = 1'b0;
   assign irq_jump = jump_q;
   assign irq_return = ret_q;
   assign irq_wake = wake_q;

   // ==========================================================
   // assertions
   a_no_take_gie: assert property (@(posedge hclk) disable iff (!hresetn)
      jump_q.valid |-> $past(gie))
      else $error("dispatch while global enable low");
   a_take_clr_gie: assert property (@(posedge hclk) disable iff (!hresetn)
      take && !wr_c |=> !gie)
      else $error("global enable not cleared on dispatch");
   a_full_block: assert property (@(posedge hclk) disable iff (!hresetn)
      stack_full |-> !take)
      else $error("dispatch with full stack");
   a_push_sp: assert property (@(posedge hclk) disable iff (!hresetn)
      take |=> sp_q == $past(sp_q) + 4'h1 && jump_q.valid)
      else $error("stack pointer not pushed");
   a_pop_pc: assert property (@(posedge hclk) disable iff (!hresetn)
      take ##1 (!take && !pop)[*1] ##1 (pop && !take)
         |=> ret_q.valid && ret_q.pc == $past(next_pc, 3))
      else $error("return pc differs from pushed pc");
   a_prio_pin0: assert property (@(posedge hclk) disable iff (!hresetn)
      take && pend[0] |=> jump_q.pc == mic_pkg::VEC_PIN0)
      else $error("pin 0 not serviced first");
   a_event_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      src_event_a[3] |=> mf_a_q[7])
      else $error("source flag not set on event");
   a_src_keep: assert property (@(posedge hclk) disable iff (!hresetn)
      take && sel == mic_pkg::MIC_SRC_MF_A && !wr_a && mf_a_q[7]
         |=> mf_a_q[7] && !mf_flag[0])
      else $error("group dispatch touched source flag");
   a_pin_clr: assert property (@(posedge hclk) disable iff (!hresetn)
      take && sel == mic_pkg::MIC_SRC_PIN0 && !pin_hit[0]
         |=> !pin_flag[0])
      else $error("pin flag not cleared on dispatch");
   a_rsvd_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      edge_q[7:4] == 4'h0 && dbnc_q[7:4] == 4'h0 && mf_b_q[7] == 1'b0
         && mf_b_q[3] == 1'b0)
      else $error("unimplemented bits set");
   a_edge_off: assert property (@(posedge hclk) disable iff (!hresetn)
      edge_q[1:0] == mic_pkg::EDGE_OFF |-> !pin_hit[0])
      else $error("disabled pin raised request");
   a_wake_new: assert property (@(posedge hclk) disable iff (!hresetn)
      src_event_a[0] && !mf_a_q[4] |=> irq_wake)
      else $error("no wake on newly set flag");
   a_pop_sp: assert property (@(posedge hclk) disable iff (!hresetn)
      pop && !take |=> sp_q == $past(sp_q) - 4'h1)
      else $error("stack pointer not popped");
   a_ret_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
      ret_q.valid |-> $past(return_from_irq_instr))
      else $error("return without return instruction");
   a_jump_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
      jump_q.valid |=> !jump_q.valid)
      else $error("second dispatch before global enable set");
   a_gie_block: assert property (@(posedge hclk) disable iff (!hresetn)
      !gie |-> !take)
      else $error("dispatch with global enable low");
   a_mf_b_event: assert property (@(posedge hclk) disable iff (!hresetn)
      src_event_b[2] |=> mf_b_q[6])
      else $error("second register flag not set on event");
   a_grp_set: assert property (@(posedge hclk) disable iff (!hresetn)
      mf_set[1] |=> mf_flag[1])
      else $error("group flag not set on enabled event");
   a_grp_vec: assert property (@(posedge hclk) disable iff (!hresetn)
      take && sel == mic_pkg::MIC_SRC_MF_B
         |=> jump_q.pc == mic_pkg::VEC_MF_B)
      else $error("wrong vector for second group");
   a_grp_keep_b: assert property (@(posedge hclk) disable iff (!hresetn)
      take && sel == mic_pkg::MIC_SRC_MF_B && !wr_b && mf_b_q[6]
         |=> mf_b_q[6])
      else $error("second group dispatch touched source flag");
   a_pin_set: assert property (@(posedge hclk) disable iff (!hresetn)
      pin_hit[1] |=> pin_flag[1])
      else $error("pin 1 flag not set on edge");
   a_pin_wake: assert property (@(posedge hclk) disable iff (!hresetn)
      pin_hit[0] && !pin_flag[0] && dbnc_q[1:0] == mic_pkg::DB_BYPASS
         |=> irq_wake)
      else $error("no wake on new pin flag");
   a_sp_bound: assert property (@(posedge hclk) disable iff (!hresetn)
      sp_q <= mic_pkg::STK_FULL)
      else $error("stack pointer beyond depth");
   a_bypass_pass: assert property (@(posedge hclk) disable iff (!hresetn)
      dbnc_q[1:0] == mic_pkg::DB_BYPASS && agree[0]
         |=> filt_q[0] == $past(s3_q[0]))
      else $error("bypassed pin not passed through");
   a_db_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      dbnc_q[1:0] != mic_pkg::DB_BYPASS && !agree[0]
         |=> filt_q[0] == $past(filt_q[0]))
      else $error("debounced pin moved while unsettled");
   a_cnt_bound: assert property (@(posedge hclk) disable iff (!hresetn)
      cnt_q[0] < mic_pkg::DB_CYC_3)
      else $error("debounce count beyond longest time");
   a_rise_only: assert property (@(posedge hclk) disable iff (!hresetn)
      edge_q[1:0] == mic_pkg::EDGE_RISE && fall[0] |-> !pin_hit[0])
      else $error("rising select took falling edge");
   a_fall_hit: assert property (@(posedge hclk) disable iff (!hresetn)
      edge_q[1:0] == mic_pkg::EDGE_FALL && fall[0] |-> pin_hit[0])
      else $error("falling select missed falling edge");
endmodule // mic_irq_ctrl

//--- verilog/mic_pkg.sv
// Purpose: shared constants and types of the interrupt controller
// Assumes: 32-bit AHB-Lite register bus, 13-bit program counter
// Notes: register offsets are byte addresses
package mic_pkg;
   // ==========================================================
   // register map
   localparam logic [7:0] OFS_MF_A = 8'h00;
   localparam logic [7:0] OFS_MF_B = 8'h04;
   localparam logic [7:0] OFS_EDGE = 8'h08;
   localparam logic [7:0] OFS_DBNC = 8'h0C;
   localparam logic [7:0] OFS_CTRL = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h14;
   // ==========================================================
   // field layouts and reset values
   localparam logic [7:0] MF_A_MASK = 8'hFF;
   localparam logic [7:0] MF_B_MASK = 8'h77;
   localparam logic [7:0] PIN_REG_MASK = 8'h0F;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int CTRL_GIE = 0;
   localparam int CTRL_PIN_EN = 1;
   localparam int CTRL_PIN_FLAG = 4;
   localparam int CTRL_MF_FLAG = 6;
   localparam int CTRL_MF_EN = 8;
   localparam logic [9:0] CTRL_MASK = 10'h3F7;
   // ==========================================================
   // edge select and debounce codes
   localparam logic [1:0] EDGE_OFF = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam logic [1:0] DB_BYPASS = 2'h0;
   localparam logic [4:0] DB_CYC_1 = 5'h08;
   localparam logic [4:0] DB_CYC_2 = 5'h10;
   localparam logic [4:0] DB_CYC_3 = 5'h18;
   // ==========================================================
   // program counter, stack, vectors (vector values arbitrary)
   localparam int PC_W = 13;
   localparam int STK_DEPTH = 8;
   localparam logic [3:0] STK_FULL = 4'h8;
   localparam logic [12:0] VEC_PIN0 = 13'h0004;
   localparam logic [12:0] VEC_PIN1 = 13'h0008;
   localparam logic [12:0] VEC_MF_A = 13'h000C;
   localparam logic [12:0] VEC_MF_B = 13'h0010;
   // ==========================================================
   // dispatched source, highest priority first
   typedef enum logic [1:0] {
      MIC_SRC_PIN0 = 2'b00,
      MIC_SRC_PIN1 = 2'b01,
      MIC_SRC_MF_A = 2'b10,
      MIC_SRC_MF_B = 2'b11
   } mic_src_t;
   typedef struct packed {
      logic valid;
      logic [12:0] pc;
   } mic_pc_t;
endpackage

//--- testbench/mic_cpu_model.sv
// Purpose: stand-in for the core fetch flow beside the controller
// Assumes: one instruction boundary per cycle while run is high
// Notes: keeps its own copy of pushed return addresses
`timescale 1ns/1ps
module mic_cpu_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic run,
   input wire logic do_ret,
   input wire mic_pkg::mic_pc_t irq_jump,
   input wire mic_pkg::mic_pc_t irq_return,
   output logic instr_boundary,
   output logic [12:0] next_pc,
   output logic return_from_irq_instr,
   output logic [12:0] exp_pop
);
   logic [12:0] pc_q;
   logic [12:0] prev_q;
   logic [3:0] sp_q;
   logic [12:0] stk_q [0:8];
   // ==========================================================
   // fetch flow
   assign instr_boundary = run;
   assign next_pc = pc_q;
   assign return_from_irq_instr = do_ret;
   assign exp_pop = (sp_q == 4'h0) ? 13'h0000 : stk_q[sp_q - 4'h1];
   // prev_q holds the pc offered at the dispatch edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pc_q <= 13'h0100;
         prev_q <= 13'h0100;
         sp_q <= 4'h0;
      end else begin
         prev_q <= pc_q;
         if (irq_jump.valid) begin
            stk_q[sp_q] <= prev_q;
            sp_q <= sp_q + 4'h1;
            pc_q <= irq_jump.pc;
         end else if (irq_return.valid) begin
            sp_q <= sp_q - 4'h1;
            pc_q <= irq_return.pc;
         end else if (run) begin
            pc_q <= pc_q + 13'h0001;
         end
      end
   end
endmodule // mic_cpu_model

//--- testbench/mic_irq_ctrl_tb.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: zero-wait register bus; pins driven straight by the bench
// Notes: table rows cover register masks; later tests hand-written
`timescale 1ns/1ps
module mic_irq_ctrl_tb;
   logic hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic hreadyout, irq_wake, instr_boundary, return_from_irq_instr;
   logic run = 1'b0, do_ret = 1'b0, fh_clk_on = 1'b1;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, w0, j0;
   logic [1:0] htrans = 2'h0, ext_irq_pin = 2'h0;
   logic [2:0] hsize = 3'h2, src_event_b = 3'h0;
   logic [3:0] src_event_a = 4'h0;
   logic [12:0] next_pc, exp_pop;
   mic_pkg::mic_pc_t irq_jump, irq_return;
   logic [31:0] mismatches = 32'h0, check_count = 32'h0, cycles = 32'h0;
   logic [31:0] jumps = 32'h0, wakes = 32'h0, last_pc = 32'h0;
   logic [39:0] rows [0:5] = '{40'h00_00FF_00FF, 40'h04_00FF_0077,
      40'h08_00FF_000F, 40'h0C_00FF_000F, 40'h10_FFFE_03F6,
      40'h20_00FF_0000};
   mic_irq_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(), .src_event_a(src_event_a),
      .src_event_b(src_event_b), .ext_irq_pin(ext_irq_pin),
      .instr_boundary(instr_boundary), .next_pc(next_pc),
      .return_from_irq_instr(return_from_irq_instr),
      .fh_clk_on(fh_clk_on), .irq_jump(irq_jump),
      .irq_return(irq_return), .irq_wake(irq_wake));
   mic_cpu_model cpu (.hclk(hclk), .hresetn(hresetn), .run(run),
      .do_ret(do_ret), .irq_jump(irq_jump), .irq_return(irq_return),
      .instr_boundary(instr_boundary), .next_pc(next_pc),
      .return_from_irq_instr(return_from_irq_instr), .exp_pop(exp_pop));
   // ==========================================================
   // helpers
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 32'h0 && check_count != 32'h0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count = check_count + 32'h1;
      if (got !== exp) begin
         mismatches = mismatches + 32'h1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic ev(input int i);
      if (i < 4) src_event_a <= 4'h1 << i;
      else src_event_b <= 3'h1 << (i - 4);
      @(posedge hclk);
      src_event_a <= 4'h0;
      src_event_b <= 3'h0;
      tick(4);
   endtask
   task automatic ret();
      do_ret <= 1'b1;
      @(posedge hclk);
      do_ret <= 1'b0;
      tick(3);
   endtask
   // ==========================================================
   // clock, monitors, timeout
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   always @(negedge hclk) begin
      if (irq_jump.valid === 1'b1) begin
         jumps = jumps + 32'h1;
         last_pc = {19'h0, irq_jump.pc};
      end
      if (irq_return.valid === 1'b1) chk({19'h0, irq_return.pc}, {19'h0, exp_pop});
      if (irq_wake === 1'b1) wakes = wakes + 32'h1;
   end
   always @(posedge hclk) begin
      cycles = cycles + 32'h1;
      if (cycles == 32'h4E20) begin
         mismatches = mismatches + 32'h1;
         print_verdict();
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      tick(4);
      hresetn <= 1'b1;
      tick(2);
      for (int r = 0; r < 6; r++) begin
         rchk(rows[r][39:32], 32'h0);
         bus(1'b1, rows[r][39:32], {16'h0, rows[r][31:16]});
         rchk(rows[r][39:32], {16'h0, rows[r][15:0]});
         bus(1'b1, rows[r][39:32], 32'h0);
      end
      for (int i = 0; i < 7; i++) begin
         w0 = wakes;
         ev(i);
         ev(i);
         chk(wakes, w0 + 32'h1);
      end
      rchk(mic_pkg::OFS_MF_A, 32'hF0);
      rchk(mic_pkg::OFS_MF_B, 32'h70);
      run <= 1'b1;
      bus(1'b1, mic_pkg::OFS_MF_A, 32'h0);
      bus(1'b1, mic_pkg::OFS_MF_B, 32'h0);
      bus(1'b1, mic_pkg::OFS_CTRL, 32'h101);
      j0 = jumps;
      ev(3);
      chk(jumps, j0);
      bus(1'b1, mic_pkg::OFS_MF_A, 32'h88);
      ev(3);
      chk(last_pc, {19'h0, mic_pkg::VEC_MF_A});
      rchk(mic_pkg::OFS_CTRL, 32'h100);
      ev(0);
      rchk(mic_pkg::OFS_MF_A, 32'h98);
      ev(3);
      rchk(mic_pkg::OFS_CTRL, 32'h140);
      chk(jumps, j0 + 32'h1);
      bus(1'b1, mic_pkg::OFS_CTRL, 32'h37);
      tick(3);
      chk(last_pc, {19'h0, mic_pkg::VEC_PIN0});
      rchk(mic_pkg::OFS_CTRL, 32'h26);
      bus(1'b1, mic_pkg::OFS_CTRL, 32'h27);
      tick(3);
      chk(last_pc, {19'h0, mic_pkg::VEC_PIN1});
      rchk(mic_pkg::OFS_CTRL, 32'h06);
      for (int k = 0; k < 3; k++) ret();
      // dispatch, one idle cycle, then return
      bus(1'b1, mic_pkg::OFS_CTRL, 32'h13);
      tick(2);
      ret();
      chk(last_pc, {19'h0, mic_pkg::VEC_PIN0});
      j0 = jumps;
      for (int k = 0; k < 9; k++) begin
         bus(1'b1, mic_pkg::OFS_CTRL, 32'h13);
         tick(4);
         chk(jumps, j0 + ((k < 8) ? k + 1 : 8));
      end
      bus(1'b0, mic_pkg::OFS_STAT, 32'h0);
      chk(rd & 32'h800, 32'h800);
      ret();
      tick(2);
      chk(jumps, j0 + 32'h9);
      for (int k = 0; k < 8; k++) ret();
      bus(1'b1, mic_pkg::OFS_MF_B, 32'h04);
      bus(1'b1, mic_pkg::OFS_CTRL, 32'h201);
      ev(6);
      chk(last_pc, {19'h0, mic_pkg::VEC_MF_B});
      ret();
      bus(1'b1, mic_pkg::OFS_CTRL, 32'h0);
      // pins: enables stay low so only the flags move
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, mic_pkg::OFS_EDGE, 32'(c * 5));
         w0 = wakes;
         ext_irq_pin <= 2'h3;
         tick(12);
         rchk(mic_pkg::OFS_CTRL, {26'h0, c[0], c[0], 4'h0});
         chk(wakes, w0 + {31'h0, c[0]});
         bus(1'b1, mic_pkg::OFS_CTRL, 32'h0);
         ext_irq_pin <= 2'h0;
         tick(12);
         rchk(mic_pkg::OFS_CTRL, {26'h0, c[1], c[1], 4'h0});
         bus(1'b1, mic_pkg::OFS_CTRL, 32'h0);
      end
      bus(1'b1, mic_pkg::OFS_EDGE, 32'h5);
      for (int k = 1; k < 4; k++) begin
         bus(1'b1, mic_pkg::OFS_DBNC, 32'(k * 5));
         ext_irq_pin <= 2'h3;
         tick(8 * k - 3);
         ext_irq_pin <= 2'h0;
         tick(40);
         rchk(mic_pkg::OFS_CTRL, 32'h0);
         ext_irq_pin <= 2'h3;
         tick(8 * k + 12);
         rchk(mic_pkg::OFS_CTRL, 32'h30);
         bus(1'b1, mic_pkg::OFS_CTRL, 32'h0);
         ext_irq_pin <= 2'h0;
         tick(40);
      end
      fh_clk_on <= 1'b0;
      w0 = wakes;
      ext_irq_pin <= 2'h3;
      tick(40);
      chk(wakes, w0);
      fh_clk_on <= 1'b1;
      bus(1'b1, mic_pkg::OFS_MF_A, 32'h5A);
      hresetn <= 1'b0;
      tick(2);
      hresetn <= 1'b1;
      tick(2);
      rchk(mic_pkg::OFS_MF_A, 32'h0);
      rchk(mic_pkg::OFS_DBNC, 32'h0);
      print_verdict();
   end
endmodule // mic_irq_ctrl_tb
